// ### host_model.sv
// host side model: command writes, status reads, acknowledge pulses
`timescale 1ns/1ps
module host_model (
  input  wire logic       core_clk,
  output logic            store_strobe,
  output logic            read_strobe,
  output logic            port_select_line,
  output logic      [7:0] wr_data,
  output logic            ack_strobe,
  input  wire logic [7:0] rd_data
);
  initial begin
    store_strobe = 1'b0;
    read_strobe = 1'b0;
    port_select_line = 1'b0;
    wr_data = 8'h00;
    ack_strobe = 1'b0;
  end
  task automatic wr(input logic a, input logic [7:0] d);
    @(negedge core_clk);
    store_strobe = 1'b1;
    port_select_line = a;
    wr_data = d;
    @(negedge core_clk);
    store_strobe = 1'b0;
    wr_data = ~d;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic a, output logic [7:0] d);
    @(negedge core_clk);
    read_strobe = 1'b1;
    port_select_line = a;
    @(negedge core_clk);
    read_strobe = 1'b0;
    @(negedge core_clk);
    d = rd_data;
  endtask
  // n pulses per acknowledge sequence
  task automatic intack(input int n);
    repeat (n) begin
      @(negedge core_clk);
      ack_strobe = 1'b1;
      @(negedge core_clk);
      ack_strobe = 1'b0;
    end
    @(negedge core_clk);
  endtask
endmodule // host_model

// ### pic_pkg.sv
// constants and word layouts for the priority interrupt resolver
// Behaviour
// - fixed ranking, level 0 highest, 7 lowest
// - acknowledge sets in-service bit, releases level
// - in-service level blocks equal and lower levels
// - auto end-of-service on final acknowledge pulse
// - non-specific end clears highest in-service bit
// - specific end clears only the named bit
// - special mask keeps masked in-service bits
// - serviced level becomes lowest on rotation
// - rotate on end command or auto end
// - set-priority makes written level lowest
// - priority update independent of end action
// - mask bit n disables request input n
// - special mask enables all unmasked levels not in service
// - gate and enable bits enter/leave special mask
// - poll makes next read an acknowledge
// - requests frozen between poll write and read
// - poll byte is flag, zeros, level
// - status select picks request or in-service
// - status select defaults to request register
// - port select one reads mask; poll overrides
// - priority word opcodes in bits 7 to 5
package pic_pkg;
  localparam logic [2:0] OP_NS_END   = 3'h1;
  localparam logic [2:0] OP_SP_END   = 3'h3;
  localparam logic [2:0] OP_ROT_NS   = 3'h5;
  localparam logic [2:0] OP_AUTO_SET = 3'h4;
  localparam logic [2:0] OP_AUTO_CLR = 3'h0;
  localparam logic [2:0] OP_ROT_SP   = 3'h7;
  localparam logic [2:0] OP_SET_PRIO = 3'h6;
  localparam logic [2:0] OP_NOP      = 3'h2;
  localparam logic [1:0] SEL_PRIO    = 2'h0;
  localparam logic [1:0] SEL_MODE    = 2'h1;
  localparam logic [2:0] LOWEST_RST  = 3'h7;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [1:0] ACKS_85     = 2'h3;
  localparam logic [1:0] ACKS_86     = 2'h2;
  localparam logic [2:0] DEFAULT_LVL = 3'h7;
  localparam logic [3:0] POLL_ZEROS  = 4'h0;

  typedef struct packed {
    logic [2:0] op;
    logic [1:0] sel;
    logic [2:0] level;
  } prio_word_t;

  typedef struct packed {
    logic       rsvd;
    logic       gate;
    logic       spec_en;
    logic [1:0] sel;
    logic       poll;
    logic       rd_en;
    logic       rd_sel;
  } mode_word_t;
endpackage

// ### priority_interrupt_resolver.sv
// priority resolution, service tracking and host access of the interrupt controller
`timescale 1ns/1ps
module priority_interrupt_resolver (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] irq_lines,
  input  wire logic       store_strobe,
  input  wire logic       read_strobe,
  input  wire logic       port_select_line,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  input  wire logic       ack_strobe,
  input  wire logic       auto_end_of_service,
  input  wire logic       mode_86,
  output logic            request_output,
  output logic      [2:0] vector_level
);
  logic [7:0] request_register_q;
  logic [7:0] in_service_register_q;
  logic [7:0] mask_register_q;
  logic [2:0] lowest_q;
  logic       special_mask_q;
  logic       status_sel_q;
  logic       poll_armed_q;
  logic       auto_rot_q;
  logic [1:0] ack_cnt_q;
  logic [7:0] rd_data_q;
  logic [2:0] vector_q;

  pic_pkg::prio_word_t pw;
  pic_pkg::mode_word_t mw;
  assign pw = pic_pkg::prio_word_t'(wr_data);
  assign mw = pic_pkg::mode_word_t'(wr_data);

  // highest set bit in the rotated order
  function automatic logic [3:0] first_set(input logic [7:0] v, input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] l;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      l = low + 3'(i) + 3'h1;
      if (v[l]) r = {1'b1, l};
    end
    return r;
  endfunction

  // host access decode
  wire wr_mask = store_strobe && port_select_line;
  wire wr_prio = store_strobe && !port_select_line && pw.sel == pic_pkg::SEL_PRIO;
  wire wr_mode = store_strobe && !port_select_line && mw.sel == pic_pkg::SEL_MODE;
  wire rd_poll = read_strobe && poll_armed_q;

  // resolution
  logic [7:0] blk_w;
  wire  [3:0] service_top = first_set(in_service_register_q, lowest_q);
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      blk_w[n] = service_top[3] &&
                 (3'(n) - lowest_q - 3'h1 >= service_top[2:0] - lowest_q - 3'h1);
    end
  end
  wire [7:0] unmasked = request_register_q & ~mask_register_q;
  wire [7:0] cand = special_mask_q ? unmasked & ~in_service_register_q
                          : unmasked & ~blk_w;
  wire [3:0] win = first_set(cand, lowest_q);
  assign request_output = win[3];

  // acknowledge sequence
  wire [1:0] acks_need  = mode_86 ? pic_pkg::ACKS_86 : pic_pkg::ACKS_85;
  wire       first_ack  = ack_strobe && ack_cnt_q == 2'h0;
  wire       last_ack   = ack_strobe && ack_cnt_q + 2'h1 == acks_need;
  wire       auto_end   = last_ack && auto_end_of_service;

  // end-of-service decode
  wire [7:0] ns_cand = special_mask_q ? in_service_register_q & ~mask_register_q
                             : in_service_register_q;
  wire [3:0] ns_top  = first_set(ns_cand, lowest_q);
  wire cmd_ns  = wr_prio && (pw.op == pic_pkg::OP_NS_END || pw.op == pic_pkg::OP_ROT_NS);
  wire cmd_sp  = wr_prio && (pw.op == pic_pkg::OP_SP_END || pw.op == pic_pkg::OP_ROT_SP);
  wire do_ns   = (cmd_ns || auto_end) && ns_top[3];
  wire [7:0] set_w = ((first_ack || rd_poll) && win[3]) ? 8'h01 << win[2:0] : 8'h00;
  wire [7:0] clr_w = (do_ns ? 8'h01 << ns_top[2:0] : 8'h00)
                   | (cmd_sp ? 8'h01 << pw.level : 8'h00);

  // priority rotation
  logic [2:0] lowest_d;
  always_comb begin
    lowest_d = lowest_q;
    if (wr_prio && (pw.op == pic_pkg::OP_SET_PRIO || pw.op == pic_pkg::OP_ROT_SP)) begin
      lowest_d = pw.level;
    end else if (wr_prio && pw.op == pic_pkg::OP_ROT_NS && ns_top[3]) begin
      lowest_d = ns_top[2:0];
    end else if (auto_end && auto_rot_q && ns_top[3]) begin
      lowest_d = ns_top[2:0];
    end
  end

  // read data
  wire [7:0] poll_word = {win[3], pic_pkg::POLL_ZEROS, win[2:0]};
  wire [7:0] status    = status_sel_q ? in_service_register_q : request_register_q;
  wire [7:0] rd_d      = rd_poll ? poll_word
                       : port_select_line ? mask_register_q : status;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_register_q    <= 8'h00;
      in_service_register_q <= 8'h00;
      lowest_q              <= pic_pkg::LOWEST_RST;
      ack_cnt_q             <= 2'h0;
      vector_q              <= pic_pkg::DEFAULT_LVL;
      rd_data_q             <= 8'h00;
    end else begin
      if (!poll_armed_q) request_register_q <= irq_lines;
      in_service_register_q <= (in_service_register_q & ~clr_w) | set_w;
      lowest_q <= lowest_d;
      if (last_ack) ack_cnt_q <= 2'h0;
      else if (ack_strobe) ack_cnt_q <= ack_cnt_q + 2'h1;
      if (first_ack) vector_q <= win[3] ? win[2:0] : pic_pkg::DEFAULT_LVL;
      if (read_strobe) rd_data_q <= rd_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_register_q <= pic_pkg::MASK_RST;
      special_mask_q  <= 1'b0;
      status_sel_q    <= 1'b0;
      poll_armed_q    <= 1'b0;
      auto_rot_q      <= 1'b0;
    end else begin
      if (wr_mask) mask_register_q <= wr_data;
      if (wr_mode && mw.gate) special_mask_q <= mw.spec_en;
      if (wr_mode && mw.rd_en) status_sel_q <= mw.rd_sel;
      if (wr_mode) poll_armed_q <= mw.poll;
      else if (read_strobe) poll_armed_q <= 1'b0;
      if (wr_prio && pw.op == pic_pkg::OP_AUTO_SET) auto_rot_q <= 1'b1;
      if (wr_prio && pw.op == pic_pkg::OP_AUTO_CLR) auto_rot_q <= 1'b0;
    end
  end

  assign rd_data      = rd_data_q;
  assign vector_level = vector_q;

  a_isr_on_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
    first_ack && win[3] |=> in_service_register_q[$past(win[2:0])])
    else $error("in-service bit not set on acknowledge");

  a_ns_end_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_ns && ns_top[3] && set_w == 8'h00 |=> !in_service_register_q[$past(ns_top[2:0])])
    else $error("non-specific end did not clear top bit");

  a_sp_end_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_sp && !do_ns && set_w == 8'h00
    |=> in_service_register_q == $past(in_service_register_q & ~(8'h01 << pw.level)))
    else $error("specific end touched wrong bits");

  a_mask_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_mask |=> mask_register_q == $past(wr_data))
    else $error("mask write lost");

  a_smm_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_mode && !mw.gate |=> special_mask_q == $past(special_mask_q))
    else $error("special mask changed with gate low");

  a_poll_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_poll |=> rd_data[6:3] == 4'h0 && rd_data[7] == $past(win[3]))
    else $error("poll byte malformed");

  a_set_prio: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_prio && pw.op == pic_pkg::OP_SET_PRIO |=> lowest_q == $past(pw.level))
    else $error("set priority not applied");

  a_poll_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
    poll_armed_q |=> request_register_q == $past(request_register_q))
    else $error("requests moved while poll pending");

  a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    read_strobe && !poll_armed_q && !port_select_line
    |=> rd_data == $past(status_sel_q ? in_service_register_q : request_register_q))
    else $error("status read returned wrong register");

  a_mask_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    read_strobe && !poll_armed_q && port_select_line |=> rd_data == $past(mask_register_q))
    else $error("mask read wrong");

  a_masked_no_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    first_ack
    |=> (in_service_register_q & ~$past(in_service_register_q) & $past(mask_register_q)) == 8'h00)
    else $error("masked level entered service");

  a_one_set_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
    first_ack
    |=> $onehot0(in_service_register_q & ~$past(in_service_register_q)))
    else $error("more than one in-service bit set");

  a_no_req_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    first_ack && !request_output && !wr_prio && !auto_end && !rd_poll
    |=> in_service_register_q == $past(in_service_register_q))
    else $error("in-service changed without request");

  a_vec_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    first_ack && !request_output
    |=> vector_level == pic_pkg::DEFAULT_LVL)
    else $error("default level not given");

  a_vec_winner: assert property (@(posedge core_clk) disable iff (!rst_n)
    first_ack && request_output
    |=> vector_level == $past(win[2:0]))
    else $error("vector level not the winner");

  a_nested_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    !special_mask_q && service_top[3] && request_output
    |-> (win[2:0] - lowest_q - 3'h1) < (service_top[2:0] - lowest_q - 3'h1))
    else $error("request not above in-service level");

  a_fixed_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    lowest_q == 3'h7 && request_register_q[0] && !mask_register_q[0] && in_service_register_q == 8'h00
    |-> request_output && win[2:0] == 3'h0)
    else $error("level zero not highest");

  a_auto_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    auto_end && ns_top[3] && set_w == 8'h00 && !cmd_sp
    |=> !in_service_register_q[$past(ns_top[2:0])])
    else $error("auto end did not clear top bit");

  a_ack_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    ack_strobe
    |-> ack_cnt_q != 2'h3)
    else $error("acknowledge count out of range");

  a_ack_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    last_ack
    |=> ack_cnt_q == 2'h0)
    else $error("acknowledge count not restarted");

  a_sp_mask_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    special_mask_q && (cmd_ns || auto_end) && !cmd_sp && set_w == 8'h00
    |=> ($past(in_service_register_q & mask_register_q) & ~in_service_register_q) == 8'h00)
    else $error("masked in-service bit cleared");

  a_rot_ns: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_ns && pw.op == pic_pkg::OP_ROT_NS && ns_top[3]
    |=> lowest_q == $past(ns_top[2:0]))
    else $error("rotation on end not applied");

  a_auto_rot: assert property (@(posedge core_clk) disable iff (!rst_n)
    auto_end && auto_rot_q && ns_top[3] && !wr_prio
    |=> lowest_q == $past(ns_top[2:0]))
    else $error("auto rotation not applied");

  a_no_rot_plain: assert property (@(posedge core_clk) disable iff (!rst_n)
    auto_end && !auto_rot_q && !wr_prio
    |=> lowest_q == $past(lowest_q))
    else $error("priority rotated without auto rotation");

  a_rot_sp: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_prio && pw.op == pic_pkg::OP_ROT_SP && set_w == 8'h00
    |=> lowest_q == $past(pw.level) && !in_service_register_q[$past(pw.level)])
    else $error("rotate on specific end wrong");

  a_nop_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_prio && pw.op == pic_pkg::OP_NOP && !ack_strobe && !rd_poll
    |=> in_service_register_q == $past(in_service_register_q) && lowest_q == $past(lowest_q))
    else $error("no-operation word changed state");

  a_mask_other: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_mask
    |=> mask_register_q == $past(mask_register_q))
    else $error("mask changed without write");

  a_smm_enter: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_mode && mw.gate
    |=> special_mask_q == $past(mw.spec_en))
    else $error("special mask not updated");

  a_smm_open: assert property (@(posedge core_clk) disable iff (!rst_n)
    special_mask_q && (request_register_q & ~mask_register_q & ~in_service_register_q) != 8'h00
    |-> request_output)
    else $error("unmasked level blocked in special mask");

  a_poll_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_poll && request_output
    |=> in_service_register_q[$past(win[2:0])])
    else $error("poll did not set in-service bit");

  a_poll_disarm: assert property (@(posedge core_clk) disable iff (!rst_n)
    read_strobe && !wr_mode
    |=> !poll_armed_q)
    else $error("poll still armed after read");

  a_poll_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_poll && request_output
    |=> rd_data[2:0] == $past(win[2:0]))
    else $error("poll level wrong");

  a_status_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_mode && !mw.rd_en
    |=> status_sel_q == $past(status_sel_q))
    else $error("status selection lost");

  a_rd_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !read_strobe
    |=> rd_data == $past(rd_data))
    else $error("read data moved without read");

  a_req_track: assert property (@(posedge core_clk) disable iff (!rst_n)
    !poll_armed_q
    |=> request_register_q == $past(irq_lines))
    else $error("request register not sampled");
endmodule // priority_interrupt_resolver

// ### priority_interrupt_resolver_tb.sv
// self-checking bench for the priority interrupt resolver
`timescale 1ns/1ps
module priority_interrupt_resolver_tb;
  logic       core_clk;
  logic       rst_n;
  logic [7:0] irq;
  logic       st, rs, ps, ack, req;
  logic       auto_eos;
  logic       m86;
  logic [7:0] wd, rdd, v;
  logic [2:0] vl;
  int         n_mismatch = 0;
  int         n_checks = 0;
  priority_interrupt_resolver uut (.core_clk(core_clk), .rst_n(rst_n), .irq_lines(irq),
    .store_strobe(st), .read_strobe(rs), .port_select_line(ps), .wr_data(wd),
    .rd_data(rdd), .ack_strobe(ack), .auto_end_of_service(auto_eos), .mode_86(m86),
    .request_output(req), .vector_level(vl));
  host_model host (.core_clk(core_clk), .store_strobe(st), .read_strobe(rs),
    .port_select_line(ps), .wr_data(wd), .ack_strobe(ack), .rd_data(rdd));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic rchk(input logic a, input logic [7:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask
  task automatic set_irq(input logic [7:0] d);
    @(negedge core_clk);
    irq = d;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic t_reset();
    rchk(1'b0, 8'h00);
    rchk(1'b1, 8'h00);
  endtask
  task automatic t_nested();
    set_irq(8'h30);
    chk({7'h00, req}, 8'h01);
    rchk(1'b0, 8'h30);
    host.intack(2);
    chk({5'h00, vl}, 8'h04);
    host.wr(1'b0, 8'h0b);
    rchk(1'b0, 8'h10);
    chk({7'h00, req}, 8'h00);
    set_irq(8'h38);
    chk({7'h00, req}, 8'h01);
    host.intack(2);
    chk({5'h00, vl}, 8'h03);
  endtask
  task automatic t_eoi();
    rchk(1'b0, 8'h18);
    set_irq(8'h00);
    host.wr(1'b0, 8'h20);
    rchk(1'b0, 8'h10);
    host.wr(1'b0, 8'h64);
    rchk(1'b0, 8'h00);
  endtask
  task automatic t_mask_poll();
    host.wr(1'b1, 8'h08);
    rchk(1'b1, 8'h08);
    set_irq(8'h08);
    chk({7'h00, req}, 8'h00);
    set_irq(8'h0c);
    host.wr(1'b0, 8'h0e);
    rchk(1'b0, 8'h82);
    host.wr(1'b0, 8'h0b);
    rchk(1'b0, 8'h04);
    host.wr(1'b0, 8'h20);
    set_irq(8'h00);
    host.wr(1'b0, 8'h0c);
    rchk(1'b0, 8'h00);
    host.wr(1'b1, 8'h00);
  endtask
  task automatic t_rotate_auto();
    host.wr(1'b0, 8'hc4);
    set_irq(8'h21);
    host.intack(2);
    chk({5'h00, vl}, 8'h05);
    host.wr(1'b0, 8'h20);
    set_irq(8'h01);
    auto_eos = 1'b1;
    host.intack(2);
    host.wr(1'b0, 8'h0b);
    rchk(1'b0, 8'h00);
    auto_eos = 1'b0;
  endtask
  task automatic t_rotation();
    host.wr(1'b0, 8'h80);
    set_irq(8'h06);
    auto_eos = 1'b1;
    host.intack(2);
    chk({5'h00, vl}, 8'h01);
    host.intack(2);
    chk({5'h00, vl}, 8'h02);
    host.intack(2);
    chk({5'h00, vl}, 8'h01);
    auto_eos = 1'b0;
    host.wr(1'b0, 8'h00);
    host.wr(1'b0, 8'he5);
    host.intack(2);
    chk({5'h00, vl}, 8'h01);
    host.wr(1'b0, 8'ha0);
    host.intack(2);
    chk({5'h00, vl}, 8'h02);
    host.wr(1'b0, 8'h62);
    rchk(1'b0, 8'h00);
    host.wr(1'b0, 8'hc7);
    set_irq(8'h00);
  endtask
  task automatic t_mode85();
    m86 = 1'b0;
    auto_eos = 1'b1;
    set_irq(8'h08);
    host.intack(2);
    chk({5'h00, vl}, 8'h03);
    rchk(1'b0, 8'h08);
    host.intack(1);
    rchk(1'b0, 8'h00);
    m86 = 1'b1;
    auto_eos = 1'b0;
    set_irq(8'h00);
  endtask
  task automatic t_special_mask();
    set_irq(8'h30);
    host.intack(2);
    host.wr(1'b0, 8'h68);
    chk({7'h00, req}, 8'h01);
    host.wr(1'b1, 8'h20);
    chk({7'h00, req}, 8'h00);
    host.wr(1'b1, 8'h10);
    host.wr(1'b0, 8'h20);
    rchk(1'b0, 8'h10);
    host.wr(1'b0, 8'h64);
    rchk(1'b0, 8'h00);
    host.wr(1'b0, 8'h48);
    host.wr(1'b1, 8'h00);
    host.intack(2);
    chk({5'h00, vl}, 8'h04);
    chk({7'h00, req}, 8'h00);
    host.wr(1'b0, 8'h20);
    set_irq(8'h00);
  endtask
  initial begin
    rst_n = 1'b0;
    irq = 8'h00;
    auto_eos = 1'b0;
    m86 = 1'b1;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_nested();
    t_eoi();
    t_mask_poll();
    t_rotate_auto();
    t_rotation();
    t_mode85();
    t_special_mask();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end
endmodule // priority_interrupt_resolver_tb
